// ---- dv/rsu_radio.sv ----
`timescale 1ns/1ns

// ****************************************************************
// Radio data line model; data on both lines are active high, not inverted.
// ****************************************************************
module rsu_radio #(
  parameter int BIT_CLKS = 40
) (
  input  wire logic aclk,
  output logic      rx_in,
  input  wire logic tx_out
);
  initial rx_in = 1'b0;

  // Sends one symbol, bit 11 first, one bit period per bit.
  task automatic send(input logic [11:0] s);
    for (int i = 11; i >= 0; i--) begin
      rx_in <= s[i];
      repeat (BIT_CLKS) @(posedge aclk);
    end
  endtask : send

  // Sends the alternating preamble, then the start symbol.
  task automatic frame;
    send(12'haaa);
    send(12'h1fe);
  endtask : frame

  // Samples two symbols mid-bit from the first rise.
  task automatic capture(output logic [23:0] q);
    q = 24'h000000;
    for (int w = 0; w < 4000 && tx_out !== 1'b1; w++) @(posedge aclk);
    repeat (BIT_CLKS / 2) @(posedge aclk);
    for (int i = 0; i < 24; i++) begin
      q = {q[22:0], tx_out};
      repeat (BIT_CLKS) @(posedge aclk);
    end
  endtask : capture
endmodule : rsu_radio

// ---- dv/rsu_top_chk.sv ----
`timescale 1ns/1ns
`include "rsu_cfg.svh"

// ****************************************************************
// Port checker.
// ****************************************************************
module rsu_top_chk #(
  parameter int BIT_CLKS = `RSU_BIT_CLKS
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        tx_out
);
  logic [11:0] hi_cnt;
  logic        w_run;
  logic        wr_seen;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_cnt  <= 12'h000;
      w_run   <= 1'b0;
      wr_seen <= 1'b0;
    end else begin
      hi_cnt  <= tx_out ? hi_cnt + 12'h001 : 12'h000;
      w_run   <= tx_out & (w_run | (s_axi_wvalid & s_axi_wready));
      wr_seen <= wr_seen | (s_axi_wvalid & s_axi_wready);
    end
  end

  sequence ar_take_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rd_wait_s;
    !s_axi_rvalid [*2] ##1 s_axi_rvalid;
  endsequence
  sequence aw_w_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  reset_idle_a: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !tx_out)
    else $error("outputs not idle after reset");
  rd_lat_a: assert property (ar_take_s |=> rd_wait_s)
    else $error("read answer not on third edge");
  wr_resp_a: assert property (aw_w_s |-> ##2 s_axi_bvalid)
    else $error("write answer not on second edge");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready
    && !s_axi_wready)
    else $error("write accepted while answer pending");
  b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  tx_run_a: assert property ($fell(tx_out) && !w_run |->
    (hi_cnt % BIT_CLKS) == 0)
    else $error("serial high run not whole bit periods");
  tx_load_a: assert property (tx_out |-> wr_seen)
    else $error("serial output active before any load");
endmodule : rsu_top_chk

bind rsu_top rsu_top_chk #(.BIT_CLKS(BIT_CLKS)) rsu_top_chk_i (.*);

// ---- dv/rsu_top_test.sv ----
`timescale 1ns/1ns
`include "rsu_cfg.svh"

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module rsu_top_test;
  import rsu_pkg::*;
  // ****************************************************************
  // Stimulus and checks.
  // ****************************************************************
  localparam rsu_sym_t SYM_A = 12'h8f1;
  localparam rsu_sym_t SYM_B = 12'hca3;
  logic        aclk, aresetn, rx_in, tx_out;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [23:0] q;
  int          n_mismatch = 0;
  int          n_tests = 0;

  rsu_top rsu_top_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_in(rx_in), .tx_out(tx_out));
  rsu_radio rsu_radio_i (.aclk(aclk), .rx_in(rx_in), .tx_out(tx_out));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] rs);
    bit b;
    b = 1'b0;
    rs = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        b = 1'b1;
        rs = bresp;
        bready <= 1'b0;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    bit b;
    b = 1'b0;
    v = 32'h0;
    rs = 2'h3;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        b = 1'b1;
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
      end
    end
  endtask : rd

  task automatic wait_st(input int b, input logic v);
    logic [31:0] s;
    logic [1:0]  rs;
    s = {32{~v}};
    for (int n = 0; n < 400 && s[b] !== v; n++) rd(`RSU_OFS_STATUS, s, rs);
    `CHK("status poll", v, s[b]);
  endtask : wait_st

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    {aresetn, awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`RSU_OFS_STATUS, d, r);
    `CHK("status reset", 32'h0, d);
    rd(`RSU_OFS_CTRL, d, r);
    `CHK("ctrl reset", 32'h0, d);
    rd(8'h10, d, r);
    `CHK("unmapped read", `RSU_RESP_SLVERR, r);
    wr(`RSU_OFS_STATUS, 32'h1, r);
    `CHK("status write", `RSU_RESP_SLVERR, r);
    wr(`RSU_OFS_TXDATA, {20'h0, SYM_A}, r);
    repeat (120) @(posedge aclk);
    `CHK("tx paused", 1'b0, tx_out);
    rd(`RSU_OFS_STATUS, d, r);
    `CHK("tx busy", 1'b1, d[`RSU_ST_BUSY]);
    wr(`RSU_OFS_TXDATA, 32'h0, r);
    fork
      rsu_radio_i.capture(q);
      begin
        wr(`RSU_OFS_CTRL, 32'h1, r);
        wait_st(`RSU_ST_BUSY, 1'b0);
        wr(`RSU_OFS_TXDATA, {20'h0, SYM_B}, r);
      end
    join
    `CHK("tx stream", {SYM_A, SYM_B}, q);
    wait_st(`RSU_ST_BUSY, 1'b0);
    wr(`RSU_OFS_CTRL, 32'h0, r);
    rsu_radio_i.frame();
    rd(`RSU_OFS_STATUS, d, r);
    `CHK("hunt disabled", 1'b0, d[`RSU_ST_START]);
    repeat (600) @(posedge aclk);
    wr(`RSU_OFS_CTRL, 32'h2, r);
    fork
      begin
        rsu_radio_i.frame();
        rsu_radio_i.send(SYM_A);
        rsu_radio_i.send(SYM_B);
      end
      begin
        wait_st(`RSU_ST_START, 1'b1);
        wait_st(`RSU_ST_READY, 1'b1);
        rd(`RSU_OFS_RXDATA, d, r);
        `CHK("rx first", {20'h0, SYM_A}, d);
        rd(`RSU_OFS_STATUS, d, r);
        `CHK("ready cleared", 1'b0, d[`RSU_ST_READY]);
        wait_st(`RSU_ST_READY, 1'b1);
        rd(`RSU_OFS_RXDATA, d, r);
        `CHK("rx second", {20'h0, SYM_B}, d);
      end
    join
    rd(`RSU_OFS_STATUS, d, r);
    `CHK("start held", 1'b1, d[`RSU_ST_START]);
    wr(`RSU_OFS_CTRL, 32'h6, r);
    wr(`RSU_OFS_CTRL, 32'h2, r);
    rd(`RSU_OFS_STATUS, d, r);
    `CHK("start cleared", 1'b0, d[`RSU_ST_START]);
    wr(`RSU_OFS_RXDATA, 32'h0, r);
    `CHK("rxdata write", `RSU_RESP_SLVERR, r);
    print_verdict();
  end
endmodule : rsu_top_test

// ---- hw/rsu_cfg.svh ----
`ifndef RSU_CFG_SVH
`define RSU_CFG_SVH

// ****************************************************************
// Symbol and timing constants.
// ****************************************************************
`define RSU_SYM_W         12
`define RSU_CNT_W         4
`define RSU_BIT_CLKS      40
`define RSU_BIT_MID       20
`define RSU_PHASE_W       6
`define RSU_START_SYM     12'h1fe
`define RSU_SYM_RST       12'h000

// ****************************************************************
// Register offsets, byte addresses.
// ****************************************************************
`define RSU_AXI_AW        8
`define RSU_OFS_CTRL      8'h00
`define RSU_OFS_TXDATA    8'h04
`define RSU_OFS_RXDATA    8'h08
`define RSU_OFS_STATUS    8'h0c

// ****************************************************************
// Control and status fields, reset values, responses.
// ****************************************************************
`define RSU_CTRL_TX_EN    0
`define RSU_CTRL_RX_EN    1
`define RSU_CTRL_SCLR     2
`define RSU_ST_BUSY       0
`define RSU_ST_READY      1
`define RSU_ST_START      2
`define RSU_ST_TXOUT      3
`define RSU_CTRL_RST      3'h0
`define RSU_RESP_OKAY     2'h0
`define RSU_RESP_SLVERR   2'h2

`endif

// ---- hw/rsu_pkg.sv ----
`include "rsu_cfg.svh"

package rsu_pkg;

  typedef logic [`RSU_SYM_W-1:0] rsu_sym_t;

  typedef enum logic [2:0] {
    RSU_REG_CTRL   = 3'h0,
    RSU_REG_TXDATA = 3'h1,
    RSU_REG_RXDATA = 3'h3,
    RSU_REG_STATUS = 3'h2,
    RSU_REG_NONE   = 3'h6
  } rsu_reg_e;

  typedef enum logic {
    RSU_RX_HUNT = 1'b0,
    RSU_RX_DATA = 1'b1
  } rsu_rx_mode_e;

  typedef enum logic [1:0] {
    RSU_RD_IDLE = 2'h0,
    RSU_RD_XFER = 2'h1,
    RSU_RD_LOAD = 2'h3,
    RSU_RD_RESP = 2'h2
  } rsu_rd_e;

  typedef struct packed {
    rsu_sym_t                shift;
    logic [`RSU_CNT_W-1:0]   cnt;
    logic [`RSU_PHASE_W-1:0] div;
    logic                    busy;
    logic                    shown;
    logic                    out;
  } rsu_tx_s;

  typedef struct packed {
    logic                    sync1;
    logic                    sync2;
    logic                    prev;
    logic [`RSU_PHASE_W-1:0] phase;
    rsu_sym_t                hunt;
    rsu_sym_t                shift;
    logic [`RSU_CNT_W-1:0]   cnt;
    rsu_rx_mode_e            mode;
    logic                    start_found;
    logic                    ready;
    rsu_sym_t                sym;
    rsu_sym_t                out_word;
  } rsu_rx_s;

  typedef struct packed {
    logic [`RSU_AXI_AW-1:0]  awaddr;
    logic                    aw_got;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    w_got;
    logic                    bvalid;
    logic [1:0]              bresp;
    rsu_rd_e                 rstate;
    rsu_reg_e                rsel;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
    logic                    tx_en;
    logic                    rx_en;
    logic                    start_clr;
  } rsu_bus_s;

endpackage : rsu_pkg

// ---- hw/rsu_rx.sv ----
`timescale 1ns/1ns
`include "rsu_cfg.svh"

module rsu_rx #(
  parameter int BIT_CLKS = `RSU_BIT_CLKS,
  parameter int BIT_MID  = `RSU_BIT_MID
) (
  input  wire logic     aclk,
  input  wire logic     aresetn,
  input  wire logic     rx_in,
  input  wire logic     rx_en,
  input  wire logic     start_clr,
  input  wire logic     rd_strobe,
  output logic          start_found,
  output logic          ready,
  output rsu_pkg::rsu_sym_t out_word
);
  import rsu_pkg::*;

  rsu_rx_s  st_reg;
  rsu_rx_s  st_next;
  logic     sample;
  logic     set_start;
  rsu_sym_t hunt_new;
  rsu_sym_t shift_new;
  logic     sym_done;

  // ****************************************************************
  // Bit alignment, hunting and deserialising.
  // ****************************************************************
  always_comb begin
    st_next       = st_reg;
    st_next.sync1 = rx_in;
    st_next.sync2 = st_reg.sync1;
    st_next.prev  = st_reg.sync2;
    if (st_reg.sync2 != st_reg.prev) begin
      st_next.phase = '0;
    end else if (st_reg.phase == BIT_CLKS[`RSU_PHASE_W-1:0] - 1'b1) begin
      st_next.phase = '0;
    end else begin
      st_next.phase = st_reg.phase + 1'b1;
    end
    sample    = (st_reg.phase == BIT_MID[`RSU_PHASE_W-1:0]);
    hunt_new  = {st_reg.hunt[`RSU_SYM_W-2:0], st_reg.sync2};
    shift_new = {st_reg.shift[`RSU_SYM_W-2:0], st_reg.sync2};
    set_start = sample && rx_en && st_reg.mode == RSU_RX_HUNT
                && hunt_new == `RSU_START_SYM;
    sym_done  = 1'b0;
    if (sample) begin
      st_next.hunt = hunt_new;
      if (st_reg.mode == RSU_RX_DATA) begin
        st_next.shift = shift_new;
        if (st_reg.cnt == `RSU_CNT_W'(`RSU_SYM_W - 1)) begin
          st_next.cnt = '0;
          st_next.sym = shift_new;
          sym_done    = 1'b1;
        end else begin
          st_next.cnt = st_reg.cnt + 1'b1;
        end
      end
    end
    if (set_start) begin
      st_next.start_found = 1'b1;
      st_next.mode        = RSU_RX_DATA;
      st_next.cnt         = '0;
    end else if (start_clr) begin
      st_next.start_found = 1'b0;
      st_next.mode        = RSU_RX_HUNT;
    end
    if (rd_strobe) begin
      st_next.out_word = st_reg.sym;
    end
    if (sym_done) begin
      st_next.ready = 1'b1;
    end else if (rd_strobe) begin
      st_next.ready = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign start_found = st_reg.start_found;
  assign ready       = st_reg.ready;
  assign out_word    = st_reg.out_word;

endmodule : rsu_rx

// ---- hw/rsu_top.sv ----
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "rsu_cfg.svh"

// Functional notes
// - A 12-bit symbol written by the host loads the transmit shifter while transmit is not busy.
// - Serial bits leave only while transmit enable is set.
// - Transmit busy is high while a loaded symbol is not fully sent.
// - A receive read strobe copies the received symbol to the output word.
// - Symbol ready rises on a full symbol and falls on a read strobe.
// - Start found rises on the start symbol and holds until cleared.
// - The start symbol is searched for only while receive is enabled.
// - Transmit bits leave on one active-high serial output.
// - Received bits come from one active-high serial input.
// - One bit period lasts forty clock cycles.
// - Start is zeros in bits 11 to 9 and 0, ones in 8 to 1.
// - After start, bits are sampled mid-period into a 12-bit shifter.

module rsu_top #(
  parameter int BIT_CLKS = `RSU_BIT_CLKS,
  parameter int BIT_MID  = `RSU_BIT_MID
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rx_in,
  output logic             tx_out
);
  import rsu_pkg::*;

  rsu_bus_s st_reg;
  rsu_bus_s st_next;
  logic     wr_exec;
  rsu_reg_e wsel;
  logic     tx_load;
  rsu_sym_t tx_word;
  logic [31:0] tx_lanes;
  logic     rd_strobe;
  logic     tx_busy;
  logic     rx_start;
  logic     rx_ready;
  rsu_sym_t rx_word;
  logic     unused_prot;

  // ****************************************************************
  // Address decode and byte-lane merge.
  // ****************************************************************
  function automatic rsu_reg_e rsu_decode(input logic [7:0] addr);
    rsu_reg_e sel;
    if (addr[1:0] != 2'h0) begin
      sel = RSU_REG_NONE;
    end else if (addr == `RSU_OFS_CTRL) begin
      sel = RSU_REG_CTRL;
    end else if (addr == `RSU_OFS_TXDATA) begin
      sel = RSU_REG_TXDATA;
    end else if (addr == `RSU_OFS_RXDATA) begin
      sel = RSU_REG_RXDATA;
    end else if (addr == `RSU_OFS_STATUS) begin
      sel = RSU_REG_STATUS;
    end else begin
      sel = RSU_REG_NONE;
    end
    return sel;
  endfunction : rsu_decode

  function automatic logic [31:0] rsu_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : rsu_merge

  // ****************************************************************
  // Bus slave and control bits.
  // ****************************************************************
  assign unused_prot   = ^{s_axi_awprot, s_axi_arprot};
  assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
  assign s_axi_wready  = !st_reg.w_got && !st_reg.bvalid;
  assign s_axi_arready = (st_reg.rstate == RSU_RD_IDLE);
  assign wr_exec       = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
  assign wsel          = rsu_decode(st_reg.awaddr);
  assign tx_lanes      = rsu_merge(32'h0, st_reg.wdata, st_reg.wstrb);
  assign tx_word       = tx_lanes[`RSU_SYM_W-1:0];
  assign tx_load       = wr_exec && wsel == RSU_REG_TXDATA;
  assign rd_strobe     = st_reg.rstate == RSU_RD_XFER
                         && st_reg.rsel == RSU_REG_RXDATA;

  always_comb begin
    logic [31:0] ctrl_v;
    ctrl_v  = 32'h0;
    st_next = st_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.awaddr = s_axi_awaddr;
      st_next.aw_got = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
      st_next.w_got = 1'b1;
    end
    if (wr_exec) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = `RSU_RESP_OKAY;
      if (wsel == RSU_REG_CTRL) begin
        ctrl_v = rsu_merge({29'h0, st_reg.start_clr, st_reg.rx_en,
                            st_reg.tx_en}, st_reg.wdata, st_reg.wstrb);
        st_next.tx_en     = ctrl_v[`RSU_CTRL_TX_EN];
        st_next.rx_en     = ctrl_v[`RSU_CTRL_RX_EN];
        st_next.start_clr = ctrl_v[`RSU_CTRL_SCLR];
      end else if (wsel == RSU_REG_NONE || wsel == RSU_REG_RXDATA
                   || wsel == RSU_REG_STATUS) begin
        st_next.bresp = `RSU_RESP_SLVERR;
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    case (st_reg.rstate)
      RSU_RD_IDLE: begin
        if (s_axi_arvalid) begin
          st_next.rsel   = rsu_decode(s_axi_araddr);
          st_next.rstate = RSU_RD_XFER;
        end
      end
      RSU_RD_XFER: begin
        st_next.rstate = RSU_RD_LOAD;
      end
      RSU_RD_LOAD: begin
        st_next.rdata = 32'h0;
        st_next.rresp = `RSU_RESP_OKAY;
        if (st_reg.rsel == RSU_REG_CTRL) begin
          st_next.rdata[`RSU_CTRL_TX_EN] = st_reg.tx_en;
          st_next.rdata[`RSU_CTRL_RX_EN] = st_reg.rx_en;
          st_next.rdata[`RSU_CTRL_SCLR]  = st_reg.start_clr;
        end else if (st_reg.rsel == RSU_REG_RXDATA) begin
          st_next.rdata[`RSU_SYM_W-1:0] = rx_word;
        end else if (st_reg.rsel == RSU_REG_STATUS) begin
          st_next.rdata[`RSU_ST_BUSY]  = tx_busy;
          st_next.rdata[`RSU_ST_READY] = rx_ready;
          st_next.rdata[`RSU_ST_START] = rx_start;
          st_next.rdata[`RSU_ST_TXOUT] = tx_out;
        end else if (st_reg.rsel != RSU_REG_TXDATA) begin
          st_next.rresp = `RSU_RESP_SLVERR;
        end
        st_next.rstate = RSU_RD_RESP;
      end
      RSU_RD_RESP: begin
        if (s_axi_rready) begin
          st_next.rstate = RSU_RD_IDLE;
        end
      end
      default: begin
        st_next.rstate = RSU_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg        <= '0;
      st_reg.rstate <= RSU_RD_IDLE;
      st_reg.rsel   <= RSU_REG_NONE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp  = st_reg.bresp;
  assign s_axi_rvalid = (st_reg.rstate == RSU_RD_RESP);
  assign s_axi_rdata  = st_reg.rdata;
  assign s_axi_rresp  = st_reg.rresp;

  // ****************************************************************
  // Transmit and receive engines.
  // ****************************************************************
  rsu_tx #(
    .BIT_CLKS (BIT_CLKS)
  ) u_tx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .load    (tx_load),
    .data    (tx_word),
    .tx_en   (st_reg.tx_en),
    .busy    (tx_busy),
    .tx_out  (tx_out)
  );

  rsu_rx #(
    .BIT_CLKS (BIT_CLKS),
    .BIT_MID  (BIT_MID)
  ) u_rx (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .rx_in       (rx_in),
    .rx_en       (st_reg.rx_en),
    .start_clr   (st_reg.start_clr),
    .rd_strobe   (rd_strobe),
    .start_found (rx_start),
    .ready       (rx_ready),
    .out_word    (rx_word)
  );

endmodule : rsu_top

// ---- hw/rsu_tx.sv ----
`timescale 1ns/1ns
`include "rsu_cfg.svh"

module rsu_tx #(
  parameter int BIT_CLKS = `RSU_BIT_CLKS
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              load,
  input  wire rsu_pkg::rsu_sym_t data,
  input  wire logic              tx_en,
  output logic                   busy,
  output logic                   tx_out
);
  import rsu_pkg::*;

  rsu_tx_s st_reg;
  rsu_tx_s st_next;

  // ****************************************************************
  // Serialiser, most significant bit first.
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    if (load && !st_reg.busy) begin
      st_next.shift = data;
      st_next.busy  = 1'b1;
      st_next.cnt   = '0;
      st_next.div   = '0;
    end else if (st_reg.busy && st_reg.shown) begin
      if (st_reg.div == BIT_CLKS[`RSU_PHASE_W-1:0] - 1'b1) begin
        st_next.div = '0;
        if (st_reg.cnt == `RSU_CNT_W'(`RSU_SYM_W - 1)) begin
          st_next.busy = 1'b0;
        end else begin
          st_next.shift = {st_reg.shift[`RSU_SYM_W-2:0], 1'b0};
          st_next.cnt   = st_reg.cnt + 1'b1;
        end
      end else begin
        st_next.div = st_reg.div + 1'b1;
      end
    end
    // The bit timer only runs on cycles whose bit was on the line.
    st_next.shown = st_next.busy && tx_en;
    st_next.out   = st_next.shown && st_next.shift[`RSU_SYM_W-1];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy   = st_reg.busy;
  assign tx_out = st_reg.out;

endmodule : rsu_tx
